// File: design/reset_cause_pkg.sv
// Constants shared by the reset cause and core status logic
package reset_cause_pkg;
  // Register offsets
  localparam logic [7:0] OFS_BANK_SELECT = 8'h01;
  localparam logic [7:0] OFS_PC_LOW_BYTE = 8'h02;
  localparam logic [7:0] OFS_CPU_FLAGS_STATUS = 8'h03;
  localparam logic [7:0] OFS_INDIRECT_POINTER = 8'h04;
  localparam logic [7:0] OFS_OPERATING_MODE_CONTROL = 8'h0E;
  localparam logic [7:0] OFS_WATCHDOG_CONTROL = 8'h21;
  // Status word field positions
  localparam int STATUS_INT_BIT = 7;
  localparam int STATUS_WDOG_FLAG_BIT = 4;
  localparam int STATUS_DORMANCY_BIT = 3;
  // Operating mode control field positions
  localparam int OM_CPU_CLOCK_SOURCE_SEL_BIT = 7;
  localparam int OM_IDLE_BIT = 6;
  localparam int OM_OSC_MODE_SEL_HI_BIT = 1;
  localparam int OM_OSC_MODE_SEL_LO_BIT = 0;
  // Watchdog control field positions
  localparam int WD_ENABLE_BIT = 7;
  // Writable bit masks
  localparam logic [7:0] BANK_SELECT_MASK = 8'h13;
  localparam logic [7:0] STATUS_WR_MASK = 8'h87;
  localparam logic [7:0] OPMODE_WR_MASK = 8'hC3;
  localparam logic [7:0] WDOG_CTRL_MASK = 8'h8F;
  // Reset values
  localparam logic [7:0] BANK_SELECT_RST = 8'h00;
  localparam logic [7:0] PC_LOW_BYTE_RST = 8'h00;
  localparam logic [7:0] STATUS_POR_RST = 8'h18;
  localparam logic [7:0] INDIRECT_POINTER_POR = 8'hFF;
  localparam logic [7:0] OPMODE_RST = 8'hC0;
  localparam logic [7:0] WDOG_CTRL_RST = 8'h00;
  // Timing: internal reset stretch counted from the cycle a source is accepted
  localparam int CLK_MHZ = 50;
  localparam int RESET_HOLD_NS = 1000;
  localparam int RESET_HOLD_CYCLES = (RESET_HOLD_NS * CLK_MHZ + 999) / 1000;
  // Processor run states
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SLEEP = 2'b01,
    ST_IDLE = 2'b10,
    ST_HOLD = 2'b11
  } cpu_state_t;
endpackage : reset_cause_pkg

// File: design/pin_sync2.sv
// Two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module pin_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  // First stage is read only by the second
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule : pin_sync2
`default_nettype wire

// File: design/reset_cause_status_logic.sv
// Reset source arbitration, reset cause flags and core register reset values
`timescale 1ns/1ps
`default_nettype none
module reset_cause_status_logic (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic ext_reset_pin_n,
  input wire logic low_voltage_reset,
  input wire logic [1:0] osc_mode_option,
  input wire logic watchdog_timeout,
  input wire logic watchdog_clear_instr,
  input wire logic sleep_instruction,
  input wire logic pin_change_wake,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic core_reset_n,
  output logic cpu_asleep,
  output logic watchdog_flag,
  output logic dormancy_mark,
  output logic watchdog_enable,
  output logic [1:0] osc_mode_sel,
  output logic cpu_clock_source_sel
);
  import reset_cause_pkg::*;

  logic rst_meta_r;
  logic rst_n;
  logic [3:0] pins_sync;
  logic pin_low;
  logic lowv_act;
  logic [1:0] opt_sync;
  cpu_state_t state_r;
  cpu_state_t state_nxt;
  logic [5:0] hold_cnt_r;
  logic [5:0] hold_cnt_nxt;
  logic por_pending_r;
  logic [7:0] bank_r;
  logic [7:0] pc_low_r;
  logic [7:0] status_r;
  logic [7:0] pointer_r;
  logic [7:0] opmode_r;
  logic [7:0] wdog_ctrl_r;
  logic [7:0] bank_nxt;
  logic [7:0] pc_low_nxt;
  logic [7:0] status_nxt;
  logic [7:0] pointer_nxt;
  logic [7:0] opmode_nxt;
  logic [7:0] wdog_ctrl_nxt;
  logic [7:0] rdata_nxt;

  // Power-on reset: asynchronous assert, released through two flops
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  pin_sync2 #(
    .WIDTH(4),
    .RST_VAL(4'h8)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in({ext_reset_pin_n, low_voltage_reset, osc_mode_option}),
    .sync_out(pins_sync)
  );

  assign pin_low = ~pins_sync[3];
  assign lowv_act = pins_sync[2];
  assign opt_sync = pins_sync[1:0];

  // Accepted events, highest priority first
  wire asleep = (state_r == ST_SLEEP) || (state_r == ST_IDLE);
  wire live = (state_r != ST_HOLD);
  wire wdt_armed = wdog_ctrl_r[WD_ENABLE_BIT];
  wire ev_lowv = live && lowv_act;
  wire ev_pin = live && !lowv_act && pin_low;
  wire ev_wdt = live && !lowv_act && !pin_low && watchdog_timeout && wdt_armed;
  wire any_rst = ev_lowv || ev_pin || ev_wdt;
  wire ev_wake = asleep && !any_rst && pin_change_wake;
  wire ev_wdog_clear = (state_r == ST_RUN) && !any_rst && watchdog_clear_instr;
  wire ev_sleep = (state_r == ST_RUN) && !any_rst && !ev_wdog_clear && sleep_instruction;
  // reset held while the pin stays low
  wire hold_done = (hold_cnt_r == 6'h00) && !pin_low && !lowv_act;

  // Register write decode
  wire wr_bank = reg_wr && (reg_addr == OFS_BANK_SELECT);
  wire wr_pc_low = reg_wr && (reg_addr == OFS_PC_LOW_BYTE);
  wire wr_status = reg_wr && (reg_addr == OFS_CPU_FLAGS_STATUS);
  wire wr_pointer = reg_wr && (reg_addr == OFS_INDIRECT_POINTER);
  wire wr_opmode = reg_wr && (reg_addr == OFS_OPERATING_MODE_CONTROL);
  wire wr_wdog_ctrl = reg_wr && (reg_addr == OFS_WATCHDOG_CONTROL);

  // Run state: any reset forces hold, sleep picks idle or sleep
  assign state_nxt = any_rst ? ST_HOLD :
                     ev_wake ? ST_RUN :
                     ev_sleep ? (opmode_r[OM_IDLE_BIT] ? ST_IDLE : ST_SLEEP) :
                     ((state_r == ST_HOLD) && hold_done) ? ST_RUN :
                     state_r;
  assign hold_cnt_nxt = any_rst ? 6'(RESET_HOLD_CYCLES - 1) :
                        (hold_cnt_r != 6'h00) ? hold_cnt_r - 6'h01 : hold_cnt_r;

  // core registers cleared by every reset
  assign bank_nxt = any_rst ? BANK_SELECT_RST :
                    wr_bank ? (reg_wdata & BANK_SELECT_MASK) : bank_r;
  assign pc_low_nxt = any_rst ? PC_LOW_BYTE_RST : wr_pc_low ? reg_wdata : pc_low_r;
  // pointer to all ones only on power-like reset
  // wake-up keeps core registers
  // A write racing a pin or watchdog reset is dropped, so the pointer keeps its value
  assign pointer_nxt = ev_lowv ? INDIRECT_POINTER_POR :
                       (wr_pointer && !any_rst) ? reg_wdata : pointer_r;
  // clock bits set, oscillator mode from option word
  // Reloaded through the whole hold: the option synchroniser restarts with power-on reset
  wire mode_load = any_rst || (state_r == ST_HOLD);
  assign opmode_nxt = mode_load ? (OPMODE_RST | {6'h00, opt_sync}) :
                      wr_opmode ? (reg_wdata & OPMODE_WR_MASK) : opmode_r;
  assign wdog_ctrl_nxt = any_rst ? WDOG_CTRL_RST :
                         wr_wdog_ctrl ? (reg_wdata & WDOG_CTRL_MASK) : wdog_ctrl_r;

  // Cause flags; hardware events win over software writes
  wire t_old = status_r[STATUS_WDOG_FLAG_BIT];
  wire p_old = status_r[STATUS_DORMANCY_BIT];
  wire t_new = ev_lowv ? 1'b1 :
               ev_pin ? (asleep ? 1'b1 : t_old) :
               ev_wdt ? 1'b0 :
               (ev_wake || ev_wdog_clear || ev_sleep) ? 1'b1 : t_old;
  wire p_new = ev_lowv ? 1'b1 :
               ev_pin ? (asleep ? 1'b0 : p_old) :
               ev_wdt ? (asleep ? 1'b0 : p_old) :
               (ev_wake || ev_sleep) ? 1'b0 :
               ev_wdog_clear ? 1'b1 : p_old;
  // arithmetic flags kept, zeroed only on power-like reset
  wire [2:0] zdc_new = ev_lowv ? 3'h0 : (wr_status && !any_rst) ? reg_wdata[2:0] : status_r[2:0];
  wire int_new = any_rst ? 1'b0 :
                 wr_status ? reg_wdata[STATUS_INT_BIT] : status_r[STATUS_INT_BIT];
  assign status_nxt = {int_new, 2'b00, t_new, p_new, zdc_new};

  // Read mux, answered one cycle after the strobe
  assign rdata_nxt = !reg_rd ? 8'h00 :
                     (reg_addr == OFS_BANK_SELECT) ? bank_r :
                     (reg_addr == OFS_PC_LOW_BYTE) ? pc_low_r :
                     (reg_addr == OFS_CPU_FLAGS_STATUS) ? status_r :
                     (reg_addr == OFS_INDIRECT_POINTER) ? pointer_r :
                     (reg_addr == OFS_OPERATING_MODE_CONTROL) ? opmode_r :
                     (reg_addr == OFS_WATCHDOG_CONTROL) ? wdog_ctrl_r : 8'h00;

  // Sequencer state; power-on starts in hold with a full stretch
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_HOLD;
      hold_cnt_r <= 6'(RESET_HOLD_CYCLES - 1);
      por_pending_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      por_pending_r <= 1'b0;
    end
  end

  // power-on values of the core registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bank_r <= BANK_SELECT_RST;
      pc_low_r <= PC_LOW_BYTE_RST;
      status_r <= STATUS_POR_RST;
      pointer_r <= INDIRECT_POINTER_POR;
      opmode_r <= OPMODE_RST;
      wdog_ctrl_r <= WDOG_CTRL_RST;
    end else begin
      bank_r <= bank_nxt;
      pc_low_r <= pc_low_nxt;
      status_r <= status_nxt;
      pointer_r <= pointer_nxt;
      opmode_r <= opmode_nxt;
      wdog_ctrl_r <= wdog_ctrl_nxt;
    end
  end

  // Output flops; core reset follows the next state, no lag
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
      core_reset_n <= 1'b0;
      cpu_asleep <= 1'b0;
    end else begin
      reg_rdata <= rdata_nxt;
      core_reset_n <= (state_nxt != ST_HOLD);
      cpu_asleep <= (state_nxt == ST_SLEEP) || (state_nxt == ST_IDLE);
    end
  end

  // flags and mode bits exported from their register bits
  assign watchdog_flag = status_r[STATUS_WDOG_FLAG_BIT];
  assign dormancy_mark = status_r[STATUS_DORMANCY_BIT];
  assign watchdog_enable = wdog_ctrl_r[WD_ENABLE_BIT];
  assign osc_mode_sel = opmode_r[OM_OSC_MODE_SEL_HI_BIT:OM_OSC_MODE_SEL_LO_BIT];
  assign cpu_clock_source_sel = opmode_r[OM_CPU_CLOCK_SOURCE_SEL_BIT];

  // Checks on the sequencer and flag updates
  a_reset_entry: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (live && (lowv_act || pin_low)) |=> (!core_reset_n && state_r == ST_HOLD))
    else $error("reset source did not enter hold");

  a_por_flags: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    por_pending_r |-> (watchdog_flag && dormancy_mark && pointer_r == INDIRECT_POINTER_POR))
    else $error("power-on flags or pointer wrong");

  a_pin_run_keep: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (ev_pin && state_r == ST_RUN) |=>
      (watchdog_flag == $past(watchdog_flag) && dormancy_mark == $past(dormancy_mark)))
    else $error("pin reset while running changed flags");

  a_pin_wake_flags: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (ev_pin && asleep) |=> (watchdog_flag && !dormancy_mark))
    else $error("pin wake flags wrong");

  a_wdt_run_flags: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (ev_wdt && !asleep) |=> (!watchdog_flag && dormancy_mark == $past(dormancy_mark)))
    else $error("watchdog reset while running flags wrong");

  a_wdt_wake_flags: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (ev_wdt && asleep) |=> (!watchdog_flag && !dormancy_mark))
    else $error("watchdog wake flags wrong");

  a_change_wake: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ev_wake |=> (watchdog_flag && !dormancy_mark && !cpu_asleep && core_reset_n))
    else $error("port change wake wrong");

  a_watchdog_clear_instr_flags: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ev_wdog_clear |=> (watchdog_flag && dormancy_mark))
    else $error("watchdog clear flags wrong");

  a_sleep_flags: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ev_sleep |=> (watchdog_flag && !dormancy_mark && cpu_asleep))
    else $error("sleep instruction flags wrong");

  a_core_clear: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (ev_pin || ev_wdt) |=> (pc_low_r == 8'h00 && bank_r == 8'h00
      && !status_r[STATUS_INT_BIT] && pointer_r == $past(pointer_r)))
    else $error("core registers not reinitialised");

  a_wake_keeps: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (ev_wake && !reg_wr) |=> (pc_low_r == $past(pc_low_r) && bank_r == $past(bank_r)
      && pointer_r == $past(pointer_r) && opmode_r == $past(opmode_r)))
    else $error("wake-up changed core registers");

  a_arith_keep: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ((ev_pin || ev_wdt || ev_wake) && !wr_status) |=> (status_r[2:0] == $past(status_r[2:0])))
    else $error("arithmetic flags lost");

  a_mode_load: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    mode_load |=> (cpu_clock_source_sel && opmode_r[OM_IDLE_BIT]
      && osc_mode_sel == $past(opt_sync)))
    else $error("mode bits not loaded on reset");

  // Core reset is low in the hold cycle and the one after it
  a_pin_hold: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_HOLD && pin_low) |-> !core_reset_n [*2])
    else $error("reset released while pin low");

  // Checks on watchdog entry and clear, release, low-voltage reset and the read port
  a_wdt_entry: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ev_wdt |=> (!core_reset_n && state_r == ST_HOLD))
    else $error("watchdog time-out did not enter hold");

  a_hold_stretch: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_HOLD && hold_cnt_r != 6'h00) |=> !core_reset_n)
    else $error("reset released before stretch ran out");

  a_hold_release: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (state_r == ST_HOLD && hold_done) |=> core_reset_n)
    else $error("reset not released after stretch");

  a_lowv_flags: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ev_lowv |=> (watchdog_flag && dormancy_mark && status_r[2:0] == 3'h0
      && pointer_r == INDIRECT_POINTER_POR))
    else $error("low-voltage reset flags wrong");

  a_lowv_core: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ev_lowv |=> (pc_low_r == PC_LOW_BYTE_RST && bank_r == BANK_SELECT_RST
      && !status_r[STATUS_INT_BIT]))
    else $error("low-voltage reset left core registers");

  a_wdog_off: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    any_rst |=> !watchdog_enable)
    else $error("watchdog left enabled after reset");

  a_rdata_idle: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !reg_rd |=> (reg_rdata == 8'h00))
    else $error("read data not idle");

  a_status_read: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (reg_rd && reg_addr == OFS_CPU_FLAGS_STATUS) |=> (reg_rdata == $past(status_r)))
    else $error("status read data wrong");

  a_watchdog_clear_instr_running: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ev_wdog_clear |=> (core_reset_n && !cpu_asleep))
    else $error("watchdog clear changed run state");
endmodule : reset_cause_status_logic
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the reset cause and core status logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import reset_cause_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic ext_reset_pin_n = 1'b1;
  logic low_voltage_reset = 1'b0;
  logic [1:0] osc_mode_option = 2'b10;
  logic watchdog_timeout = 1'b0;
  logic watchdog_clear_instr = 1'b0;
  logic sleep_instruction = 1'b0;
  logic pin_change_wake = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic core_reset_n, cpu_asleep, watchdog_flag, dormancy_mark, watchdog_enable;
  logic cpu_clock_source_sel;
  logic [1:0] osc_mode_sel;
  int fail_count = 0;
  int checks_done = 0;

  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;

  reset_cause_status_logic i_dut (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .ext_reset_pin_n(ext_reset_pin_n),
    .low_voltage_reset(low_voltage_reset),
    .osc_mode_option(osc_mode_option),
    .watchdog_timeout(watchdog_timeout),
    .watchdog_clear_instr(watchdog_clear_instr),
    .sleep_instruction(sleep_instruction),
    .pin_change_wake(pin_change_wake),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .core_reset_n(core_reset_n),
    .cpu_asleep(cpu_asleep),
    .watchdog_flag(watchdog_flag),
    .dormancy_mark(dormancy_mark),
    .watchdog_enable(watchdog_enable),
    .osc_mode_sel(osc_mode_sel),
    .cpu_clock_source_sel(cpu_clock_source_sel)
  );

  // Verdict and end of run, also reached when a wait runs out
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  // Byte compare, unknowns never match
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask : rd

  // Status byte through the bus and the two flag ports
  task automatic st(input logic [7:0] exp);
    rd("status", OFS_CPU_FLAGS_STATUS, exp);
    chk("watchdog_flag", {7'h00, exp[STATUS_WDOG_FLAG_BIT]}, {7'h00, watchdog_flag});
    chk("dormancy_mark", {7'h00, exp[STATUS_DORMANCY_BIT]}, {7'h00, dormancy_mark});
  endtask : st

  // One-cycle event: 0 sleep, 1 port wake, 2 watchdog clear, 3 watchdog time-out
  task automatic pulse(input int k);
    @(posedge clk_sys);
    case (k)
      0: sleep_instruction <= 1'b1;
      1: pin_change_wake <= 1'b1;
      2: watchdog_clear_instr <= 1'b1;
      default: watchdog_timeout <= 1'b1;
    endcase
    @(posedge clk_sys);
    sleep_instruction <= 1'b0;
    pin_change_wake <= 1'b0;
    watchdog_clear_instr <= 1'b0;
    watchdog_timeout <= 1'b0;
    #1;
  endtask : pulse

  // Bounded wait on the core reset level
  task automatic wait_core(input logic lvl);
    int n = 0;
    while (core_reset_n !== lvl && n < 300) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (core_reset_n !== lvl) begin
      fail_count++;
      $display("[FAIL] core_reset_n expected %b seen %b", lvl, core_reset_n);
      final_report();
    end
  endtask : wait_core

  // Pin (0) or low-voltage (1) reset, held past the stretch time
  task automatic hw_reset(input int k);
    @(posedge clk_sys);
    if (k == 0) begin
      ext_reset_pin_n <= 1'b0;
    end else begin
      low_voltage_reset <= 1'b1;
    end
    wait_core(1'b0);
    repeat (80) @(posedge clk_sys);
    #1;
    chk("core_reset_n held", 8'h00, {7'h00, core_reset_n});
    @(posedge clk_sys);
    ext_reset_pin_n <= 1'b1;
    low_voltage_reset <= 1'b0;
    wait_core(1'b1);
  endtask : hw_reset

  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    wait_core(1'b1);
    st(STATUS_POR_RST);
    rd("pointer", OFS_INDIRECT_POINTER, 8'hFF);
    rd("pc_low", OFS_PC_LOW_BYTE, 8'h00);
    rd("bank", OFS_BANK_SELECT, 8'h00);
    rd("opmode", OFS_OPERATING_MODE_CONTROL, 8'hC2);
    chk("osc_mode_sel", 8'h02, {6'h00, osc_mode_sel});
    $display("test power_on done");
    wr(OFS_BANK_SELECT, 8'hFF);
    wr(OFS_PC_LOW_BYTE, 8'h33);
    wr(OFS_INDIRECT_POINTER, 8'h5A);
    wr(OFS_CPU_FLAGS_STATUS, 8'hFF);
    wr(OFS_WATCHDOG_CONTROL, 8'hFF);
    wr(8'h50, 8'hAA);
    rd("bank", OFS_BANK_SELECT, 8'h13);
    rd("unmapped", 8'h50, 8'h00);
    rd("wdog_ctrl", OFS_WATCHDOG_CONTROL, 8'h8F);
    chk("wdog_enable", 8'h01, {7'h00, watchdog_enable});
    st(8'h9F);
    $display("test registers done");
    pulse(0);
    chk("asleep", 8'h01, {7'h00, cpu_asleep});
    st(8'h97);
    pulse(1);
    chk("asleep", 8'h00, {7'h00, cpu_asleep});
    st(8'h97);
    rd("pc_low", OFS_PC_LOW_BYTE, 8'h33);
    rd("pointer", OFS_INDIRECT_POINTER, 8'h5A);
    rd("bank", OFS_BANK_SELECT, 8'h13);
    pulse(2);
    st(8'h9F);
    $display("test sleep_wake done");
    pulse(3);
    wait_core(1'b0);
    wait_core(1'b1);
    st(8'h0F);
    rd("pc_low", OFS_PC_LOW_BYTE, 8'h00);
    rd("bank", OFS_BANK_SELECT, 8'h00);
    rd("pointer", OFS_INDIRECT_POINTER, 8'h5A);
    rd("wdog_ctrl", OFS_WATCHDOG_CONTROL, 8'h00);
    rd("opmode", OFS_OPERATING_MODE_CONTROL, 8'hC2);
    hw_reset(0);
    st(8'h0F);
    $display("test run_resets done");
    wr(OFS_WATCHDOG_CONTROL, 8'h80);
    pulse(0);
    st(8'h17);
    pulse(3);
    wait_core(1'b0);
    wait_core(1'b1);
    st(8'h07);
    chk("asleep", 8'h00, {7'h00, cpu_asleep});
    wr(OFS_PC_LOW_BYTE, 8'h44);
    pulse(0);
    hw_reset(0);
    st(8'h17);
    rd("pc_low", OFS_PC_LOW_BYTE, 8'h00);
    chk("asleep", 8'h00, {7'h00, cpu_asleep});
    $display("test sleep_resets done");
    hw_reset(1);
    st(8'h18);
    rd("pointer", OFS_INDIRECT_POINTER, 8'hFF);
    chk("clk_src", 8'h01, {7'h00, cpu_clock_source_sel});
    $display("test low_voltage done");
    final_report();
  end
endmodule : tb_top
`default_nettype wire
